// ### logic/lcm_period_timer.sv
`timescale 1ns/1ps

// Counts the cycles of one modulation period and marks its last cycle
module lcm_period_timer
	import lcm_pkg::*;
#(
	parameter int CNT_W = LCM_CNT_W
)
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [CNT_W-1:0] on_len,
	input wire logic [CNT_W-1:0] per_len,
	output logic period_end,
	output logic on_phase
);

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Last cycle of the period, lengths below one treated as one
	assign period_end = (per_len <= CNT_W'(1)) || (cnt_r >= per_len - CNT_W'(1));
	assign on_phase = cnt_r < on_len;
	assign cnt_nxt = period_end ? '0 : cnt_r + CNT_W'(1);

	// Cycle counter within the period
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

endmodule

// ### logic/lcm_pkg.sv
package lcm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Bus geometry and period counter width
	localparam int LCM_DATA_W = 32;
	localparam int LCM_ADDR_W = 12;
	localparam int LCM_IDX_W = 10;
	localparam int LCM_CNT_W = 8;

	// Register indices, byte address is four times the index
	localparam logic [LCM_IDX_W-1:0] LCM_IDX_MOD_CTRL = 10'h002;
	localparam logic [LCM_IDX_W-1:0] LCM_IDX_DRIVE = 10'h003;
	localparam logic [LCM_IDX_W-1:0] LCM_IDX_STATUS = 10'h004;

	// Reset values
	localparam logic [7:0] LCM_MOD_CTRL_RST = 8'h00;
	localparam logic LCM_DRIVE_RST = 1'b0;

	// Control field layout
	localparam int LCM_ONT_LSB = 3;
	localparam int LCM_ONT_W = 5;
	localparam int LCM_CFG_LSB = 0;
	localparam int LCM_CFG_W = 3;

	// Status field layout
	localparam int LCM_ST_PIN = 0;
	localparam int LCM_ST_RUN = 1;
	localparam int LCM_ST_ONPH = 2;
	localparam int LCM_ST_ACT_LSB = 8;
	localparam int LCM_ST_TICKS_LSB = 16;
	localparam int LCM_TICK_CNT_W = 16;

	// Duty configurations
	typedef enum logic [2:0]
	{
		LCM_CFG_OFF = 3'h0,
		LCM_CFG_D50 = 3'h1,
		LCM_CFG_D33 = 3'h2,
		LCM_CFG_D25 = 3'h3,
		LCM_CFG_D67 = 3'h4,
		LCM_CFG_D75 = 3'h5,
		LCM_CFG_RSVD = 3'h6,
		LCM_CFG_HF = 3'h7
	} lcm_cfg_type;

	////////////////////////////////////////////////////////////////////////////
	// On-phase multiple of the on-time count plus one
	function automatic logic [1:0] lcm_on_mult(input logic [2:0] cfg);
		case (cfg)
			LCM_CFG_D67: lcm_on_mult = 2'h2;
			LCM_CFG_D75: lcm_on_mult = 2'h3;
			default: lcm_on_mult = 2'h1;
		endcase
	endfunction

	// Off-phase multiple of the on-time count plus one
	function automatic logic [1:0] lcm_off_mult(input logic [2:0] cfg);
		case (cfg)
			LCM_CFG_D50: lcm_off_mult = 2'h1;
			LCM_CFG_D33: lcm_off_mult = 2'h2;
			LCM_CFG_D25: lcm_off_mult = 2'h3;
			LCM_CFG_D67: lcm_off_mult = 2'h1;
			LCM_CFG_D75: lcm_off_mult = 2'h1;
			default: lcm_off_mult = 2'h0;
		endcase
	endfunction

	// True for the configurations that run a modulated pulse train
	function automatic logic lcm_is_mod(input logic [2:0] cfg);
		lcm_is_mod = (cfg != LCM_CFG_OFF) && (cfg != LCM_CFG_RSVD);
	endfunction

endpackage

// ### logic/lcm_top.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps

module lcm_top
	import lcm_pkg::*;
#(
	parameter int ADDR_W = LCM_ADDR_W,
	parameter int CNT_W = LCM_CNT_W
)
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [LCM_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [LCM_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic led_drive_output,
	output logic period_tick
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0] mod_ctrl_r;
	logic [7:0] act_ctrl_r;
	logic drive_level_bit_r;
	logic run_r;
	logic run_nxt;
	logic led_q_r;
	logic led_q_nxt;
	logic hf_q_r;
	logic hf_nxt;
	logic tick_r;
	logic [LCM_TICK_CNT_W-1:0] tick_cnt_r;
	logic [LCM_DATA_W-1:0] prdata_r;
	logic [LCM_DATA_W-1:0] rd_nxt;
	logic pslverr_r;
	logic [LCM_IDX_W-1:0] reg_idx;
	logic aligned;
	logic hit_ctrl;
	logic hit_drive;
	logic hit_status;
	logic hit_any;
	logic setup;
	logic wr_ctrl;
	logic wr_drive;
	logic [2:0] act_cfg;
	logic [LCM_ONT_W-1:0] act_ont;
	logic [2:0] new_cfg;
	logic [CNT_W-1:0] unit_len;
	logic [CNT_W-1:0] on_len;
	logic [CNT_W-1:0] per_len;
	logic period_end;
	logic on_phase;

	////////////////////////////////////////////////////////////////////////////
	// APB decode, zero wait states
	assign reg_idx = paddr[LCM_IDX_W+1:2];
	assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:LCM_IDX_W+2] == '0);
	assign hit_ctrl = aligned && (reg_idx == LCM_IDX_MOD_CTRL);
	assign hit_drive = aligned && (reg_idx == LCM_IDX_DRIVE);
	assign hit_status = aligned && (reg_idx == LCM_IDX_STATUS);
	assign hit_any = hit_ctrl || hit_drive || hit_status;
	assign setup = psel && !penable;
	assign wr_ctrl = psel && penable && pwrite && hit_ctrl && pstrb[0];
	assign wr_drive = psel && penable && pwrite && hit_drive && pstrb[0];
	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;

	// Read mux, reserved bits read as zero
	always_comb
	begin
		rd_nxt = '0;
		if (hit_ctrl)
			rd_nxt[7:0] = mod_ctrl_r;
		else if (hit_drive)
			rd_nxt[0] = drive_level_bit_r;
		else if (hit_status)
		begin
			rd_nxt[LCM_ST_PIN] = led_q_r;
			rd_nxt[LCM_ST_RUN] = run_r;
			rd_nxt[LCM_ST_ONPH] = on_phase;
			rd_nxt[LCM_ST_ACT_LSB +: 8] = act_ctrl_r;
			rd_nxt[LCM_ST_TICKS_LSB +: LCM_TICK_CNT_W] = tick_cnt_r;
		end
	end

	// Read data and error captured in the setup cycle, valid in access
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prdata_r <= '0;
			pslverr_r <= 1'b0;
		end
		else if (setup)
		begin
			prdata_r <= pwrite ? '0 : rd_nxt;
			pslverr_r <= !hit_any || (pwrite && hit_status);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Software control register
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			mod_ctrl_r <= LCM_MOD_CTRL_RST;
		else if (wr_ctrl)
			mod_ctrl_r <= pwdata[7:0];
	end

	// Port data bit that forces the pin high
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			drive_level_bit_r <= LCM_DRIVE_RST;
		else if (wr_drive)
			drive_level_bit_r <= pwdata[0];
	end

	// Working copy reloaded only at the end of a period
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			act_ctrl_r <= LCM_MOD_CTRL_RST;
		else if (period_end)
			act_ctrl_r <= mod_ctrl_r;
	end

	////////////////////////////////////////////////////////////////////////////
	// Phase lengths from the working copy
	assign act_cfg = act_ctrl_r[LCM_CFG_LSB +: LCM_CFG_W];
	assign act_ont = act_ctrl_r[LCM_ONT_LSB +: LCM_ONT_W];
	assign new_cfg = mod_ctrl_r[LCM_CFG_LSB +: LCM_CFG_W];
	assign unit_len = CNT_W'(act_ont) + CNT_W'(1);

	always_comb
	begin
		on_len = CNT_W'(lcm_on_mult(act_cfg) * unit_len);
		per_len = CNT_W'((lcm_on_mult(act_cfg) + lcm_off_mult(act_cfg)) * unit_len);
		if (act_cfg == LCM_CFG_HF)
			per_len = CNT_W'(1);
		else if (!lcm_is_mod(act_cfg))
			per_len = unit_len;
	end

	lcm_period_timer #(
		.CNT_W(CNT_W)
	) u_period (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.on_len(on_len),
		.per_len(per_len),
		.period_end(period_end),
		.on_phase(on_phase)
	);

	////////////////////////////////////////////////////////////////////////////
	// Modulation runs from a period start while the drive bit is low
	always_comb
	begin
		run_nxt = run_r;
		if (drive_level_bit_r)
			run_nxt = 1'b0;
		else if (period_end)
			run_nxt = (new_cfg != LCM_CFG_OFF) && (new_cfg != LCM_CFG_RSVD);
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			run_r <= 1'b0;
		else
			run_r <= run_nxt;
	end

	// Pin level, low is the on phase
	always_comb
	begin
		led_q_nxt = 1'b1;
		hf_nxt = 1'b0;
		if (drive_level_bit_r)
			led_q_nxt = 1'b1;
		else if (!lcm_is_mod(act_cfg))
			led_q_nxt = 1'b0;
		else if (!run_r)
			led_q_nxt = 1'b1;
		else if (act_cfg == LCM_CFG_HF)
		begin
			led_q_nxt = 1'b1;
			hf_nxt = 1'b1;
		end
		else
			led_q_nxt = !on_phase;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			led_q_r <= 1'b0;
			hf_q_r <= 1'b0;
		end
		else
		begin
			led_q_r <= led_q_nxt;
			hf_q_r <= hf_nxt;
		end
	end

	// Clock gating of the pin; leaving this mode live may glitch
	assign led_drive_output = hf_q_r ? sys_clk : led_q_r;

	////////////////////////////////////////////////////////////////////////////
	// Timer prescale tick and a wrapping count of periods
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tick_r <= 1'b0;
			tick_cnt_r <= '0;
		end
		else
		begin
			tick_r <= period_end;
			if (period_end)
				tick_cnt_r <= tick_cnt_r + LCM_TICK_CNT_W'(1);
		end
	end

	assign period_tick = tick_r;

endmodule

// ### sim/lcm_led_model.sv
`timescale 1ns/1ps
// Emitter on the pin: lit while the pin sinks
module lcm_led_model
(
	input wire logic rst_b,
	input wire logic led_drive_output,
	output int lit
);
	// One count per start of light, gated carrier too
	always @(negedge led_drive_output or negedge rst_b)
	begin
		if (!rst_b)
			lit <= 0;
		else
			lit <= lit + 1;
	end
endmodule

// ### sim/lcm_top_monitor.sv
`timescale 1ns/1ps
// Pin timing against the control seen on the bus
module lcm_chk
#(
	parameter int ADDR_W = 12
)
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic led_drive_output,
	input wire logic period_tick
);
	logic [7:0] ctl_r;
	logic drv_r;
	logic led_q_r;
	logic [8:0] q_r;
	logic [7:0] gap_r;
	logic [7:0] run_r;
	logic w;
	logic st;
	int n;
	int cf;
	int per;
	int onl;
	////////////////////////////////////////////////////////////////////////////
	// Write decode; settled once two longest periods pass
	assign w = psel && penable && pwrite && pready && pstrb[0];
	assign st = q_r > 9'h104;
	// Expected period and low length
	always_comb
	begin
		n = ctl_r[7:3] + 1;
		cf = ctl_r[2:0];
		per = cf == 7 ? 1 : cf % 6 == 0 ? n : cf < 4 ? (cf + 1) * n : (cf - 1) * n;
		onl = cf == 4 || cf == 5 ? (cf - 2) * n : n;
	end
	// Shadow registers and run counters
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctl_r <= 8'h00;
			drv_r <= 1'b0;
			led_q_r <= 1'b0;
			q_r <= 9'h000;
			gap_r <= 8'h00;
			run_r <= 8'h00;
		end
		else
		begin
			if (w && paddr == ADDR_W'(12'h008))
				ctl_r <= pwdata[7:0];
			if (w && paddr == ADDR_W'(12'h00c))
				drv_r <= pwdata[0];
			q_r <= w ? 9'h000 : q_r + 9'(q_r != 9'h1ff);
			led_q_r <= led_drive_output;
			gap_r <= period_tick ? 8'h01 : gap_r + 8'h01;
			run_r <= led_drive_output == led_q_r ? run_r + 8'h01 : 8'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_err; psel && penable && paddr[1:0] != 2'h0 |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("no error");
	property p_per; st && period_tick |-> gap_r == per; endproperty
	a_per: assert property (p_per) else $error("bad period");
	property p_run; st && !drv_r && cf > 0 && cf < 6 && led_drive_output != led_q_r
		|-> run_r == (led_drive_output ? onl : per - onl); endproperty
	a_run: assert property (p_run) else $error("bad phase");
	property p_beg; period_tick && !drv_r && q_r > 9'h001 |=> !led_drive_output; endproperty
	a_beg: assert property (p_beg) else $error("bad start");
	property p_rsv; st && !drv_r && cf % 6 == 0 |-> !led_drive_output; endproperty
	a_rsv: assert property (p_rsv) else $error("not low");
	property p_drv; drv_r |=> led_drive_output; endproperty
	a_drv: assert property (p_drv) else $error("not high");
	property p_hf; @(negedge sys_clk) disable iff (!rst_b)
		st && !drv_r && cf == 7 |-> led_drive_output; endproperty
	a_hf: assert property (p_hf) else $error("not gated");
	c_hf: cover property (st && cf == 7 && !drv_r);
	c_beg: cover property (period_tick && !drv_r && cf == 1);
	c_err: cover property (pslverr && penable);
endmodule

bind lcm_top lcm_chk #(.ADDR_W(ADDR_W)) chk_u (.*);

// ### sim/testbench.sv
`timescale 1ns/1ps
// Register tasks and mode sweeps
module testbench
	import lcm_pkg::*;
;
	localparam logic [11:0] A_CTL = {LCM_IDX_MOD_CTRL, 2'h0};
	localparam logic [11:0] A_DRV = {LCM_IDX_DRIVE, 2'h0};
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic led_drive_output;
	logic period_tick;
	logic [31:0] q;
	logic e;
	int failures = 0;
	int tests_run = 0;
	int lit;
	int tk = 0;
	int l0;
	int t0;
	int c;
	int m;
	////////////////////////////////////////////////////////////////////////////
	// Clock, design, emitter, tick count
	always #10 sys_clk = ~sys_clk;
	lcm_top dut_u (.*);
	lcm_led_model led_u (.*);
	always @(posedge sys_clk)
	begin
		if (period_tick === 1'b1)
			tk <= tk + 1;
	end
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
		tests_run++;
		if (y !== x)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", s, x, y);
		end
	endtask
	// Transfer held until ready, then one idle cycle
	task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && k < 50)
		begin
			k++;
			@(posedge sys_clk);
		end
		if (k >= 50)
			failures++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	// Set a mode, settle, count over 384 cycles
	task automatic mode;
		xf(1'b1, A_CTL, {24'h0, m[4:0], c[2:0]});
		repeat (300) @(posedge sys_clk);
		l0 = lit;
		t0 = tk;
		repeat (384) @(posedge sys_clk);
	endtask
	function automatic int ef(input int c, input int n);
		ef = c == 7 ? 384 : c % 6 == 0 ? 0 : 384 / (c < 4 ? (c + 1) * n : (c - 1) * n);
	endfunction
	task automatic results;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		chk("pin", 32'h0, {31'h0, led_drive_output});
		xf(1'b0, A_CTL, 32'h0);
		chk("ctl", 32'h0, q);
		xf(1'b0, 12'h020, 32'h0);
		chk("err", 32'h1, {31'h0, e});
		pstrb <= 4'h0;
		xf(1'b1, A_CTL, 32'hff);
		pstrb <= 4'hf;
		xf(1'b0, A_CTL, 32'h0);
		chk("strobe", 32'h0, q);
		xf(1'b1, A_CTL, 32'hffffff0b);
		xf(1'b0, A_CTL, 32'h0);
		chk("ctl", 32'h0b, q);
		for (int k = 0; k < 13; k++)
		begin
			c = k < 10 ? k % 5 + 1 : k == 10 ? 6 : k == 11 ? 0 : 7;
			m = k < 5 ? 0 : k < 10 ? 31 : 5;
			mode;
			chk("pulses", ef(c, m + 1), lit - l0);
		end
		xf(1'b1, A_DRV, 32'h1);
		c = 1;
		m = 1;
		mode;
		chk("dark", 32'h0, lit - l0);
		chk("ticks", 32'h60, tk - t0);
		xf(1'b1, A_DRV, 32'h0);
		@(posedge sys_clk);
		for (int k = 0; k < 10 && period_tick !== 1'b1; k++)
			@(posedge sys_clk);
		chk("tick", 32'h1, {31'h0, period_tick});
		@(posedge sys_clk);
		chk("start", 32'h0, {31'h0, led_drive_output});
		results;
	end
	// Watchdog
	initial
	begin
		#400000;
		failures++;
		results;
	end
endmodule
